// >>> cad_comb_adaption.v
`timescale 1ns/1ps
`include "cad_defines.vh"
// Contract
// - Two-bit rate compensation picks the quadrature default for other pixel rates.
// - NTSC steps 3-line to 2-line to simple; control can skip 2-line.
// - Architecture choice ignores mix factor; never offered for PAL. The code also forces lower 2-line in PAL when 3-line is off.
// - Adaption threshold picks 5, 15, 25 or 50 percent of full scale.
// - Smoothing bit low filters the per-pixel comb selection.
// - Fallback mode acts only with 3-line comb; 2-line means no adaption.
// - Mode 00 picks best of 3-line, upper and lower 2-line, NTSC.
// - Mode 01 falls back to lower 2-line when 3-line fails.
// - Mode 10 keeps 3-line always and sends larger errors to table.
// - Mode 11 picks the better of two 3-line combs, PAL only.
// - Two-bit active filter select per pixel, readable at 4Bh.
// - NTSC table errors follow the active comb.
// - PAL feeds lower errors to the table, except in mode 10, where it feeds the larger errors.
// - Packing field arranges error bits into the 8-bit address.
// - 256 by 5 programmable table gives the mix value.
// - Code 0 special, 1 gives 0, 2-30 pass, 31 gives 32.
// - Special-function field sets luma and chroma paths for code 0.
// - Flat-with-notch routes flat input through quarter-rate notch.
// - Smoothing filter bypassable; held and bypassed on special function.
// - Current table output readable at 4Bh.
// - Correlation from upper versus lower error differences, percent of scale.
// - Crossfade adds mix times combed high luma; chroma subtracts it.
// - Lower and upper luma errors come from rectified line differences.
module cad_comb_adaption #(
  parameter EW = 8
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_pal_mode,
  input wire i_arch_three_line,
  input wire i_skip_two_line,
  input wire [1:0] i_rate_compensation_select,
  input wire [1:0] i_adaption_threshold,
  input wire i_fast_select,
  input wire [1:0] i_fallback_mode,
  input wire [1:0] i_table_input_packing,
  input wire [1:0] i_zero_code_function,
  input wire i_mix_smoothing_bypass,
  input wire i_three_fail,
  input wire [EW-1:0] i_upper_luma_error,
  input wire [EW-1:0] i_upper_magnitude_error,
  input wire [EW-1:0] i_upper_phase_error,
  input wire [EW-1:0] i_lower_luma_error,
  input wire [EW-1:0] i_lower_magnitude_error,
  input wire [EW-1:0] i_lower_phase_error,
  input wire i_tab_we,
  input wire [7:0] i_tab_addr,
  input wire [4:0] i_tab_wdata,
  input wire [7:0] i_reg_addr,
  output reg [7:0] o_reg_rdata,
  output reg [1:0] o_rate_comp,
  output reg [1:0] o_active_filter_select,
  output reg [5:0] o_mix,
  output reg o_special,
  output reg o_luma_comb,
  output reg o_chroma_comb,
  output reg o_luma_flat_notch
);
  ////////////////////////////////////////////////////////////////////////////
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n = rst_sync_ff;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scale threshold fraction (1/64 units) to error width
  function [EW-1:0] thr_of;
    input [1:0] code;
    reg [6:0] f;
    reg [EW+6:0] p;
    begin
      case (code)
        2'h0: f = `CAD_THR_5;
        2'h1: f = `CAD_THR_15;
        2'h2: f = `CAD_THR_25;
        default: f = `CAD_THR_50;
      endcase
      p = {7'h00, {EW{1'b1}}} * {{EW{1'b0}}, f};
      thr_of = p[EW+5:6];
    end
  endfunction

  function [EW-1:0] absdiff;
    input [EW-1:0] a;
    input [EW-1:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  function [EW-1:0] maxof;
    input [EW-1:0] a;
    input [EW-1:0] b;
    begin
      maxof = (a > b) ? a : b;
    end
  endfunction

  // Zero-code paths as {luma comb, chroma comb, luma flat with notch}
  function [2:0] zero_code_paths;
    input [1:0] code;
    begin
      case (code)
        2'h0: zero_code_paths = 3'h4;
        2'h1: zero_code_paths = 3'h2;
        2'h2: zero_code_paths = 3'h1;
        default: zero_code_paths = 3'h3;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: correlation and raw comb choice
  wire [EW-1:0] thr = thr_of(i_adaption_threshold);
  wire [EW-1:0] d_luma = absdiff(i_upper_luma_error, i_lower_luma_error);
  wire [EW-1:0] d_phase = absdiff(i_upper_phase_error, i_lower_phase_error);
  wire [EW-1:0] d_mag = absdiff(i_upper_magnitude_error, i_lower_magnitude_error);
  wire decorrelated = (d_luma > thr) || (d_phase > thr) || (d_mag > thr);
  // Errors arrive rectified from line differences, so plain unsigned sums suffice
  wire [EW:0] up_sum = {1'b0, i_upper_luma_error} + {1'b0, i_upper_magnitude_error};
  wire [EW:0] lo_sum = {1'b0, i_lower_luma_error} + {1'b0, i_lower_magnitude_error};
  wire upper_better = up_sum < lo_sum;

  reg [1:0] nxt_sel;
  // Choice uses only error signals, never the mix value
  always @* begin
    nxt_sel = `CAD_SEL_THREE;
    if (!i_arch_three_line) begin
      nxt_sel = `CAD_SEL_LOWER;
    end else begin
      case (i_fallback_mode)
        `CAD_FB_BEST3: begin
          if (!i_pal_mode && i_three_fail && decorrelated) begin
            if (i_skip_two_line) nxt_sel = `CAD_SEL_SIMPLE;
            else nxt_sel = upper_better ? `CAD_SEL_UPPER : `CAD_SEL_LOWER;
          end
        end
        `CAD_FB_LOWER: begin
          if (!i_pal_mode && i_three_fail) begin
            nxt_sel = i_skip_two_line ? `CAD_SEL_SIMPLE : `CAD_SEL_LOWER;
          end
        end
        `CAD_FB_FIXED: nxt_sel = `CAD_SEL_THREE;
        `CAD_FB_PAL2: begin
          // Two 3-line candidates encoded as three and upper-three
          if (i_pal_mode && upper_better) nxt_sel = `CAD_SEL_UPPER;
        end
        default: nxt_sel = `CAD_SEL_THREE;
      endcase
    end
  end

  // Selection smoothing: change only when two pixels agree
  reg [1:0] cand_ff;
  reg [1:0] sel_ff;
  wire [1:0] sel_now = i_fast_select ? nxt_sel :
    ((nxt_sel == cand_ff) ? nxt_sel : sel_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Error set for the table
  reg [EW-1:0] e_y;
  reg [EW-1:0] e_m;
  reg [EW-1:0] e_p;
  always @* begin
    e_y = i_lower_luma_error;
    e_m = i_lower_magnitude_error;
    e_p = i_lower_phase_error;
    if (i_pal_mode && i_fallback_mode != `CAD_FB_FIXED) begin
      e_y = i_lower_luma_error;
    end else begin
      case (sel_now)
        `CAD_SEL_UPPER: begin
          e_y = i_upper_luma_error;
          e_m = i_upper_magnitude_error;
          e_p = i_upper_phase_error;
        end
        `CAD_SEL_LOWER: e_y = i_lower_luma_error;
        default: begin
          e_y = maxof(i_upper_luma_error, i_lower_luma_error);
          e_m = maxof(i_upper_magnitude_error, i_lower_magnitude_error);
          e_p = maxof(i_upper_phase_error, i_lower_phase_error);
        end
      endcase
    end
  end

  reg [7:0] addr;
  always @* begin
    case (i_table_input_packing)
      2'h0: addr = {e_p[EW-1:EW-2], e_m[EW-1:EW-3], e_y[EW-1:EW-3]};
      2'h1: addr = {e_m[EW-1:EW-4], e_y[EW-1:EW-4]};
      2'h2: addr = {e_p[EW-1:EW-3], e_m[EW-1:EW-3], e_y[EW-1:EW-2]};
      default: addr = {e_p[EW-1:EW-4], e_m[EW-1:EW-4]};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: table lookup; contents undefined until software loads them
  reg [4:0] table_mem [0:255];
  reg [4:0] tab_out_ff;
  reg [1:0] sel2_ff;
  always @(posedge i_clk) begin
    if (i_tab_we) table_mem[i_tab_addr] <= i_tab_wdata;
  end

  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cand_ff <= `CAD_SEL_THREE;
      sel_ff <= `CAD_SEL_THREE;
      tab_out_ff <= 5'h00;
      sel2_ff <= `CAD_SEL_THREE;
    end else begin
      cand_ff <= nxt_sel;
      sel_ff <= sel_now;
      tab_out_ff <= table_mem[addr];
      sel2_ff <= sel_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 3: code to mix factor
  reg [5:0] mix_raw;
  always @* begin
    if (tab_out_ff == 5'h01) mix_raw = 6'h00;
    else if (tab_out_ff == `CAD_TAB_TOP) mix_raw = `CAD_MIX_ALL_COMB;
    else mix_raw = {1'b0, tab_out_ff};
  end
  wire special = (tab_out_ff == 5'h00);
  wire [2:0] zero_paths = zero_code_paths(i_zero_code_function);

  ////////////////////////////////////////////////////////////////////////////
  // Status word; top bit reads zero so the reserved bit stays stable for software
  reg [7:0] status_word;
  always @* begin
    status_word = 8'h00;
    status_word[`CAD_STAT_OUT_LSB +: 5] = tab_out_ff;
    status_word[`CAD_STAT_SEL_LSB +: 2] = sel2_ff;
  end

  wire [5:0] mix_sm;
  cad_mix_smoother u_smooth (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_bypass(i_mix_smoothing_bypass),
    .i_hold(special),
    .i_mix(mix_raw),
    .o_mix(mix_sm)
  );

  reg [1:0] sel3_ff;
  reg special3_ff;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel3_ff <= `CAD_SEL_THREE;
      special3_ff <= 1'b0;
    end else begin
      sel3_ff <= sel2_ff;
      special3_ff <= special;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the crossfade, mix scales combed high luma downstream
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rate_comp <= 2'h0;
      o_active_filter_select <= `CAD_SEL_THREE;
      o_mix <= 6'h00;
      o_special <= 1'b0;
      o_luma_comb <= 1'b0;
      o_chroma_comb <= 1'b0;
      o_luma_flat_notch <= 1'b0;
      o_reg_rdata <= 8'h00;
    end else begin
      // Passed on only; the quadrature separator outside this block applies it
      o_rate_comp <= i_rate_compensation_select;
      o_active_filter_select <= sel3_ff;
      o_mix <= mix_sm;
      o_special <= special3_ff;
      o_luma_comb <= special3_ff && zero_paths[2];
      o_chroma_comb <= special3_ff && zero_paths[1];
      o_luma_flat_notch <= special3_ff && zero_paths[0];
      if (i_reg_addr == `CAD_REG_STATUS) begin
        o_reg_rdata <= status_word;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end
endmodule // cad_comb_adaption

// >>> cad_comb_props_properties.sv
`timescale 1ns/1ps
module cad_comb_props (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_pal_mode,
  input wire i_arch_three_line,
  input wire i_skip_two_line,
  input wire [1:0] i_rate_compensation_select,
  input wire [1:0] i_fallback_mode,
  input wire i_mix_smoothing_bypass,
  input wire i_three_fail,
  input wire [7:0] i_reg_addr,
  input wire [7:0] o_reg_rdata,
  input wire [1:0] o_rate_comp,
  input wire [1:0] o_active_filter_select,
  input wire [5:0] o_mix,
  input wire o_special,
  input wire o_luma_comb,
  input wire o_chroma_comb,
  input wire o_luma_flat_notch
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Eight-cycle holds cover sync reset plus pipeline
  wire fl = !i_pal_mode && i_arch_three_line && i_fallback_mode == 2'h1 && i_three_fail;
  sequence s_to_lower; (fl && !i_skip_two_line)[*8]; endsequence
  sequence s_to_simple; (fl && i_skip_two_line)[*8]; endsequence
  sequence s_fixed; (!i_pal_mode && i_arch_three_line && i_fallback_mode == 2'h2)[*8]; endsequence
  property p_to_lower; s_to_lower |-> o_active_filter_select == 2'h3; endproperty
  a_to_lower: assert property (p_to_lower) else $error("no lower fallback");
  property p_to_simple; s_to_simple |-> o_active_filter_select == 2'h0; endproperty
  a_to_simple: assert property (p_to_simple) else $error("no skip to simple");
  property p_fixed; s_fixed |-> o_active_filter_select == 2'h1; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed comb left");
  property p_two; (!i_arch_three_line)[*8] |-> o_active_filter_select == 2'h3; endproperty
  a_two: assert property (p_two) else $error("two-line adapted");
  property p_byp; i_mix_smoothing_bypass[*8] |-> o_mix != 6'h01 && o_mix != 6'h1f; endproperty
  a_byp: assert property (p_byp) else $error("unmapped mix");
  property p_range; o_mix <= 6'h20 && o_reg_rdata[7] == 1'b0; endproperty
  a_range: assert property (p_range) else $error("mix out of range");
  property p_quiet; !o_special |-> !(o_luma_comb || o_chroma_comb || o_luma_flat_notch); endproperty
  a_quiet: assert property (p_quiet) else $error("flags without special");
  property p_notch; o_luma_flat_notch |-> !o_luma_comb && o_special; endproperty
  a_notch: assert property (p_notch) else $error("notch with comb luma");
  property p_unmap; (i_reg_addr != 8'h4b)[*4] |-> o_reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_rate; $stable(i_rate_compensation_select)[*5] |->
    o_rate_comp == i_rate_compensation_select; endproperty
  a_rate: assert property (p_rate) else $error("rate select lost");
endmodule // cad_comb_props
bind cad_comb_adaption cad_comb_props u_props (.i_clk, .i_reset_n, .i_pal_mode,
  .i_arch_three_line, .i_skip_two_line, .i_rate_compensation_select, .i_fallback_mode,
  .i_mix_smoothing_bypass, .i_three_fail, .i_reg_addr, .o_reg_rdata, .o_rate_comp,
  .o_active_filter_select, .o_mix, .o_special, .o_luma_comb, .o_chroma_comb,
  .o_luma_flat_notch);

// >>> cad_defines.vh
`ifndef CAD_DEFINES_VH
`define CAD_DEFINES_VH
// Status register offset
`define CAD_REG_STATUS 8'h4b
// Status field positions
`define CAD_STAT_OUT_LSB 0
`define CAD_STAT_SEL_LSB 5
// Active filter codes
`define CAD_SEL_SIMPLE 2'h0
`define CAD_SEL_THREE 2'h1
`define CAD_SEL_UPPER 2'h2
`define CAD_SEL_LOWER 2'h3
// Fallback-mode codes
`define CAD_FB_BEST3 2'h0
`define CAD_FB_LOWER 2'h1
`define CAD_FB_FIXED 2'h2
`define CAD_FB_PAL2 2'h3
// Mix factor limits
`define CAD_MIX_ALL_COMB 6'h20
`define CAD_TAB_TOP 5'h1f
// Threshold fractions of full scale, in 1/64 steps
`define CAD_THR_5 7'h03
`define CAD_THR_15 7'h0a
`define CAD_THR_25 7'h10
`define CAD_THR_50 7'h20
`define CAD_PIPE_LAT 3
`endif

// >>> cad_fail_source.sv
`timescale 1ns/1ps
module cad_fail_source (
  input wire i_clk,
  input wire i_pal_mode,
  input wire [7:0] i_line0,
  input wire [7:0] i_line1,
  input wire [7:0] i_line2,
  output reg [7:0] o_upper_luma_error,
  output reg [7:0] o_lower_luma_error,
  output reg [7:0] o_uncombed_delayed
);
  function [7:0] ad(input [7:0] a, input [7:0] b);
    ad = a > b ? a - b : b - a;
  endfunction
  // Falling edge launch keeps errors settled at the pixel edge
  always @(negedge i_clk) begin
    o_lower_luma_error <= ad(i_line0, i_line1);
    o_upper_luma_error <= ad(i_pal_mode ? i_line0 : i_line1, i_line2);
    // Uncombed channel taken one line late to match the comb latency
    o_uncombed_delayed <= i_line1;
  end
endmodule // cad_fail_source

// >>> cad_mix_smoother.v
`timescale 1ns/1ps
`include "cad_defines.vh"
module cad_mix_smoother (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_bypass,
  input wire i_hold,
  input wire [5:0] i_mix,
  output reg [5:0] o_mix
);
  reg [5:0] held_ff;
  // Current code averaged with the last one, so filter and bypass share latency
  wire [6:0] sum = {1'b0, i_mix} + {1'b0, held_ff} + 7'h01;
  wire [5:0] avg = sum[6:1];
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_ff <= 6'h00;
      o_mix <= 6'h00;
    end else begin
      // Input frozen on special function
      if (!i_hold) begin
        held_ff <= i_mix;
      end
      // Two-tap average stops pixel-rate flicker between comb and simple
      if (i_hold || i_bypass) begin
        o_mix <= i_mix;
      end else begin
        o_mix <= avg;
      end
    end
  end
endmodule // cad_mix_smoother

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  logic clk = 0, rst_n = 0, pal = 0, arch = 0, skip = 0, fast = 1, byp = 1, fail = 0, we = 0;
  logic [1:0] rc = 0, thr = 0, fb = 0, pk = 0, zf = 0;
  logic [7:0] l0 = 0, l1 = 0, l2 = 0, um = 0, up = 0, lm = 0, lp = 0, ta = 0, ra = 0;
  logic [4:0] td = 0;
  logic [4:0] tab [256];
  wire [7:0] ue, le, rd, unc;
  wire [1:0] rco, sel;
  wire [5:0] mix;
  wire sp, lc, cc, fn;
  int errors = 0, tests_run = 0, cyc = 0;
  logic [31:0] seed = 32'hc85e;
  always #5 clk = ~clk;
  cad_fail_source u_src (.i_clk(clk), .i_pal_mode(pal), .i_line0(l0), .i_line1(l1),
    .i_line2(l2), .o_upper_luma_error(ue), .o_lower_luma_error(le),
    .o_uncombed_delayed(unc));
  cad_comb_adaption u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_pal_mode(pal),
    .i_arch_three_line(arch), .i_skip_two_line(skip), .i_rate_compensation_select(rc),
    .i_adaption_threshold(thr), .i_fast_select(fast), .i_fallback_mode(fb),
    .i_table_input_packing(pk), .i_zero_code_function(zf), .i_mix_smoothing_bypass(byp),
    .i_three_fail(fail), .i_upper_luma_error(ue), .i_upper_magnitude_error(um),
    .i_upper_phase_error(up), .i_lower_luma_error(le), .i_lower_magnitude_error(lm),
    .i_lower_phase_error(lp), .i_tab_we(we), .i_tab_addr(ta), .i_tab_wdata(td),
    .i_reg_addr(ra), .o_reg_rdata(rd), .o_rate_comp(rco), .o_active_filter_select(sel),
    .o_mix(mix), .o_special(sp), .o_luma_comb(lc), .o_chroma_comb(cc),
    .o_luma_flat_notch(fn));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] ad(input logic [7:0] a, b);
    return a > b ? a - b : b - a;
  endfunction
  function automatic logic [7:0] mx(input logic [7:0] a, b);
    return a > b ? a : b;
  endfunction
  // Adaption threshold as a fraction of full scale in 64ths
  function automatic logic [7:0] tv(input logic [1:0] c);
    logic [15:0] f;
    f = c == 2'h0 ? 16'h3 : c == 2'h1 ? 16'ha : c == 2'h2 ? 16'h10 : 16'h20;
    f = (16'hff * f) >> 6;
    return f[7:0];
  endfunction
  function automatic logic [7:0] paddr(input logic [7:0] y, m, p);
    case (pk)
      2'h0: return {p[7:6], m[7:5], y[7:5]};
      2'h1: return {m[7:4], y[7:4]};
      2'h2: return {p[7:5], m[7:5], y[7:6]};
      default: return {p[7:4], m[7:4]};
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [4:0] d);
    @(negedge clk);
    we = 1;
    ta = a;
    td = d;
    tab[a] = d;
    @(negedge clk);
    we = 0;
  endtask
  task give_verdict();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [7:0] y, m, p, a, uy;
    logic [4:0] t;
    logic [1:0] es;
    logic dec;
    repeat (4) @(negedge clk);
    `CHK({sel, mix, sp, lc, cc, fn, rd, rco}, {2'h1, 20'h0})
    rst_n = 1;
    repeat (4) @(negedge clk);
    // Table has no reset, so every entry is written first
    for (int i = 0; i < 256; i++) begin
      r = rnd();
      wr(i[7:0], r[4:0]);
    end
    for (int i = 0; i < 48; i++) begin
      r = rnd();
      {pk, byp, rc, thr, fail, skip, fast} = r[9:0];
      zf = i < 16 ? i[3:2] : r[11:10];
      r = rnd();
      {l0, l1, l2, um} = r;
      r = rnd();
      {up, lm, lp, fb} = r[25:0];
      pal = i % 4 == 3 && i < 32;
      arch = i % 4 != 0 || i >= 32;
      if (i % 4 == 1) fb = 2'h2;
      if (i % 4 == 2) fb = 2'h1;
      if (i % 4 == 2) fail = 1;
      if (i % 4 == 3) fb = 2'h3;
      // Last third: best-of-three adaption with random threshold and fail
      if (i >= 32) fb = 2'h0;
      y = ad(l0, l1);
      uy = ad(pal ? l0 : l1, l2);
      m = lm;
      p = lp;
      dec = ad(uy, y) > tv(thr) || ad(um, lm) > tv(thr) || ad(up, lp) > tv(thr);
      es = 2'h3;
      if (i % 4 == 1) es = 2'h1;
      if (i % 4 == 2 && skip) es = 2'h0;
      if (i % 4 == 3) es = {1'b0, uy} + um < {1'b0, y} + lm ? 2'h2 : 2'h1;
      if (i >= 32) es = {1'b0, uy} + um < {1'b0, y} + lm ? 2'h2 : 2'h3;
      if (i >= 32 && skip) es = 2'h0;
      if (i >= 32 && !(fail && dec)) es = 2'h1;
      if (es == 2'h2 && !pal) begin
        y = uy;
        m = um;
        p = up;
      end
      if (es == 2'h1 && !pal) begin
        y = mx(y, uy);
        m = mx(m, um);
        p = mx(p, up);
      end
      a = paddr(y, m, p);
      // Corner codes: special, all bandsplit, all comb
      if (i < 16) wr(a, i % 4 == 0 ? 5'h00 : i[2] ? 5'h1f : 5'h01);
      repeat (12) @(negedge clk);
      ra = 8'h4b;
      repeat (4) @(negedge clk);
      t = tab[a];
      `CHK(rco, rc)
      `CHK(unc, l1)
      if (i % 4 != 3) `CHK({rd[7:5], sel}, {1'b0, es, es})
      else `CHK({rd[7:5], sel}, {1'b0, es, es})
      if (es != 2'h0) begin
        `CHK(rd[4:0], t)
        if (t == 5'h00) `CHK({sp, lc, cc, fn}, {1'b1, zf == 2'h0, zf[0], zf[1]})
        else `CHK(mix, t == 5'h01 ? 6'h00 : t == 5'h1f ? 6'h20 : {1'b0, t})
      end
      ra = r[31:24] == 8'h4b ? 8'h00 : r[31:24];
      repeat (4) @(negedge clk);
      `CHK(rd, 8'h00)
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule // testbench
